/* bench/t1ra_alarm_properties.sv */
// Port checks for the T1 receive alarm detector.
// Assumes one clock domain; bound to the top module below.
`timescale 1ns/1ps
`include "t1ra_defs.vh"
module t1ra_alarm_properties (
  input wire       i_sys_clk,             // Clock.
  input wire       i_sys_rst,             // Reset.
  input wire       i_rx_line_clk,         // Line clock.
  input wire       i_rx_positive_line_in, // Rail.
  input wire       i_rx_negative_line_in, // Rail.
  input wire       i_rx_sync_loss,        // Sync loss in.
  input wire [7:0] i_addr,                // Index.
  input wire       i_wr_stb,              // Write.
  input wire       i_rd_stb,              // Read.
  input wire [7:0] o_rd_data,             // Read data.
  input wire       o_irq,                 // Interrupt.
  input wire       o_all_ones_alarm_flag, // Flag.
  input wire       o_remote_alarm_flag,   // Flag.
  input wire       o_carrier_loss_flag,   // Flag.
  input wire       o_sync_loss_flag       // Flag.
);
  wire [3:0] flg = {o_all_ones_alarm_flag, o_remote_alarm_flag,
                    o_carrier_loss_flag, o_sync_loss_flag};
  wire       clr_ev = i_wr_stb || (i_rd_stb && i_addr == `T1RA_REG_LATCH);
  reg  [2:0] lc_q;
  reg  [7:0] zrun_q;
  // Own zero-run count; it saturates so a long loss never wraps to zero.
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      lc_q   <= 3'h0;
      zrun_q <= 8'h00;
    end else begin
      lc_q <= {lc_q[1:0], i_rx_line_clk};
      if (lc_q[1] && !lc_q[2]) begin
        if (i_rx_positive_line_in || i_rx_negative_line_in) begin
          zrun_q <= 8'h00;
        end else if (zrun_q != 8'hff) begin
          zrun_q <= zrun_q + 8'h01;
        end
      end
    end
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  property p_rd_idle;
    !$past(i_rd_stb) |-> o_rd_data == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not idle");
  property p_unmapped;
    $past(i_rd_stb) && $past(i_addr) > 8'h03 |-> o_rd_data == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_status;
    $past(i_rd_stb) && $past(i_addr) == `T1RA_REG_STATUS && $stable(flg)
      |-> o_rd_data == {4'h0, flg};
  endproperty
  a_status: assert property (p_status)
    else $error("status read differs from flags");
  property p_irq_fall;
    $fell(o_irq) |-> $past(clr_ev) || $past(clr_ev, 2) || $past(clr_ev, 3);
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("interrupt fell without clear");
  property p_los_rise;
    $rose(o_carrier_loss_flag) |-> zrun_q >= 8'hc0;
  endproperty
  a_los_rise: assert property (p_los_rise)
    else $error("carrier loss before 192 zeros");
  property p_los_hold;
    zrun_q >= 8'hc8 |-> o_carrier_loss_flag;
  endproperty
  a_los_hold: assert property (p_los_hold)
    else $error("carrier loss missing");
  property p_sync_on;
    i_rx_sync_loss [*6] |-> o_sync_loss_flag;
  endproperty
  a_sync_on: assert property (p_sync_on)
    else $error("sync loss flag missing");
  property p_ais_excl;
    $rose(o_all_ones_alarm_flag) |-> !o_carrier_loss_flag;
  endproperty
  a_ais_excl: assert property (p_ais_excl)
    else $error("all ones with carrier loss");
endmodule // t1ra_alarm_properties
bind t1ra_alarm_top t1ra_alarm_properties t1ra_alarm_properties_inst (
  .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_rx_line_clk(i_rx_line_clk),
  .i_rx_positive_line_in(i_rx_positive_line_in), .i_rx_sync_loss(i_rx_sync_loss),
  .i_rx_negative_line_in(i_rx_negative_line_in), .i_addr(i_addr), .i_wr_stb(i_wr_stb),
  .i_rd_stb(i_rd_stb), .o_rd_data(o_rd_data), .o_irq(o_irq),
  .o_all_ones_alarm_flag(o_all_ones_alarm_flag), .o_remote_alarm_flag(o_remote_alarm_flag),
  .o_carrier_loss_flag(o_carrier_loss_flag), .o_sync_loss_flag(o_sync_loss_flag)
);

/* bench/t1ra_alarm_top_tb.sv */
// Self-checking bench for the T1 receive alarm detector.
// Assumes the line model beside it and a 10 MHz system clock.
`timescale 1ns/1ps
`include "t1ra_defs.vh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
  $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module t1ra_alarm_top_tb;
  logic       i_sys_clk = 1'b0;
  logic       i_sys_rst = 1'b1;
  logic       sync_loss = 1'b0;
  logic [7:0] addr      = 8'h00;
  logic [7:0] wdata     = 8'h00;
  logic       wr_stb    = 1'b0;
  logic       rd_stb    = 1'b0;
  logic [2:0] pat       = 3'h0;
  int         fails     = 0;
  int         cmp_count = 0;
  int         cyc       = 0;
  wire        lclk, lpos, lneg, fmark, mmark, irq, f_ais, f_rem, f_los, f_syn;
  wire  [7:0] rd_data;
  wire  [3:0] flg = {f_ais, f_rem, f_los, f_syn};
  t1ra_line_model t1ra_line_model_inst (.i_pat(pat), .o_clk(lclk), .o_pos(lpos),
    .o_neg(lneg), .o_fmark(fmark), .o_mmark(mmark));
  // A short all-ones window keeps the run brief.
  t1ra_alarm_top #(.AIS_WIN_CYC(2000)) t1ra_alarm_top_inst (
    .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_rx_line_clk(lclk),
    .i_rx_positive_line_in(lpos), .i_rx_negative_line_in(lneg),
    .i_rx_frame_mark(fmark), .i_rx_mframe_mark(mmark), .i_rx_sync_loss(sync_loss),
    .i_addr(addr), .i_wr_data(wdata), .i_wr_stb(wr_stb), .i_rd_stb(rd_stb),
    .o_rd_data(rd_data), .o_irq(irq), .o_all_ones_alarm_flag(f_ais),
    .o_remote_alarm_flag(f_rem), .o_carrier_loss_flag(f_los), .o_sync_loss_flag(f_syn));
  always #50 i_sys_clk = ~i_sys_clk;
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 100000) begin
      fails++;
      print_verdict();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge i_sys_clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string nm);
    @(posedge i_sys_clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge i_sys_clk);
    rd_stb <= 1'b0;
    #1;
    `CHK(nm, e, rd_data)
  endtask
  task automatic wait_flag(input int b, input logic v, input int lim, input string nm);
    int n = 0;
    while (flg[b] !== v && n < lim) begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end
    `CHK(nm, v, flg[b])
  endtask
  task automatic settle;
    repeat (3) @(posedge i_sys_clk);
    #1;
  endtask
  initial begin
    repeat (4) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    rd_chk(`T1RA_REG_CTRL, 8'h00, "ctrl reset");
    rd_chk(`T1RA_REG_MASK, 8'h00, "mask reset");
    rd_chk(`T1RA_REG_STATUS, 8'h00, "status reset");
    wr(`T1RA_REG_MASK, 8'h02);
    wait_flag(1, 1'b1, 2500, "carrier set");
    settle();
    `CHK("irq carrier", 1'b1, irq)
    rd_chk(`T1RA_REG_LATCH, 8'h02, "latch");
    rd_chk(`T1RA_REG_LATCH, 8'h00, "latch cleared");
    `CHK("irq cleared", 1'b0, irq)
    @(posedge i_sys_clk);
    sync_loss <= 1'b1;
    wait_flag(0, 1'b1, 10, "sync set");
    settle();
    `CHK("irq masked", 1'b0, irq)
    wr(`T1RA_REG_MASK, 8'h03);
    settle();
    `CHK("irq unmasked", 1'b1, irq)
    rd_chk(`T1RA_REG_LATCH, 8'h01, "sync latch");
    @(posedge i_sys_clk);
    sync_loss <= 1'b0;
    wait_flag(0, 1'b0, 10, "sync clear");
    @(posedge i_sys_clk);
    pat <= 3'h1;
    wait_flag(1, 1'b0, 1500, "carrier clear");
    wait_flag(3, 1'b1, 5000, "all ones set");
    rd_chk(`T1RA_REG_STATUS, 8'h08, "status");
    @(posedge i_sys_clk);
    sync_loss <= 1'b1;
    wait_flag(0, 1'b1, 10, "sync with all ones");
    rd_chk(`T1RA_REG_STATUS, 8'h09, "all ones qualified");
    @(posedge i_sys_clk);
    sync_loss <= 1'b0;
    pat <= 3'h2;
    wait_flag(3, 1'b0, 5000, "all ones clear");
    wait_flag(2, 1'b1, 34000, "remote set");
    `CHK("carrier kept", 1'b0, f_los)
    @(posedge i_sys_clk);
    pat <= 3'h1;
    wait_flag(2, 1'b0, 34000, "remote clear");
    @(posedge i_sys_clk);
    pat <= 3'h3;
    wr(`T1RA_REG_CTRL, 8'h01);
    rd_chk(`T1RA_REG_CTRL, 8'h01, "ctrl twelfth");
    wait_flag(2, 1'b0, 2500, "twelfth idle");
    wait_flag(2, 1'b1, 2500, "twelfth set");
    wait_flag(2, 1'b0, 2500, "twelfth clear");
    wr(`T1RA_REG_CTRL, 8'hff);
    rd_chk(`T1RA_REG_CTRL, 8'h03, "ctrl");
    wait_flag(2, 1'b1, 9000, "data link set");
    @(posedge i_sys_clk);
    pat <= 3'h4;
    wait_flag(2, 1'b0, 9000, "data link clear");
    wr(8'h09, 8'hff);
    rd_chk(8'h09, 8'h00, "unmapped");
    rd_chk(`T1RA_REG_MASK, 8'h03, "mask kept");
    print_verdict();
  end
endmodule // t1ra_alarm_top_tb

/* bench/t1ra_line_model.sv */
// Behavioural T1 line interface: free-running line clock, framed stream.
// Assumes the bench picks the pattern; bits change on the falling edge.
`timescale 1ns/1ps
module t1ra_line_model (
  input  wire [2:0] i_pat,   // 0 zeros, 1 ones, 2 bit 2 and F zero, 3 and 4 short frames.
  output reg        o_clk,   // Line clock, 800 ns.
  output reg        o_pos,   // Positive rail.
  output reg        o_neg,   // Negative rail.
  output reg        o_fmark, // Framing bit.
  output reg        o_mmark  // Framing bit of frame 1.
);
  reg [7:0] pos_q = 8'h00;
  reg [4:0] frm_q = 5'h00;
  reg       pol_q = 1'b0;
  reg [3:0] fdl_q = 4'h0;
  reg       one;
  initial begin
    o_clk   = 1'b0;
    o_pos   = 1'b0;
    o_neg   = 1'b0;
    o_fmark = 1'b1;
    o_mmark = 1'b1;
  end
  always #400 o_clk = ~o_clk;
  // Ones alternate rails, so both inputs of the block see traffic.
  // Two-bit frames let the framing-bit alarms finish in a few thousand
  // cycles; in pattern 3 the F bits of odd frames carry eight zeros then eight ones.
  always @(negedge o_clk) begin
    if (pos_q >= ((i_pat > 3'h2) ? 8'h01 : 8'hc0)) begin
      pos_q = 8'h00;
      frm_q = (frm_q == 5'h17) ? 5'h00 : frm_q + 5'h01;
    end else begin
      pos_q = pos_q + 8'h01;
    end
    one     = (i_pat == 3'h1) || (i_pat == 3'h4) ||
              (i_pat == 3'h2 && pos_q != 8'h00 && pos_q[2:0] != 3'h2) ||
              (i_pat == 3'h3 && (pos_q != 8'h00 || fdl_q[3]));
    if (pos_q == 8'h00 && !frm_q[0]) begin
      fdl_q = fdl_q + 4'h1;
    end
    pol_q   = pol_q ^ one;
    o_pos   = one && pol_q;
    o_neg   = one && !pol_q;
    o_fmark = (pos_q == 8'h00);
    o_mmark = (pos_q == 8'h00) && (frm_q == 5'h00);
  end
endmodule // t1ra_line_model

/* hdl/t1ra_alarm_top.v */
// Receive alarm detector for one T1 framer, with status, latched
// status, mask and control registers on a plain register port.
// Assumes the line pins, line clock and framer markers are asynchronous.
//
// Overview of operation
// - The all-ones alarm sets when a 3 ms window holds 5 or fewer zeros.
// - The all-ones alarm clears when a 3 ms window holds 6 or more zeros.
// - In bit-2 mode the remote alarm sets when 254 of 256 slots show bit 2 zero.
// - In bit-2 mode the remote alarm clears when fewer than 254 of 256 do.
// - Mode select 0 picks the bit-2 method and 1 the twelfth framing-bit method.
// - In twelfth-bit mode the alarm sets after that bit is one twice in a row.
// - In twelfth-bit mode the alarm clears after that bit is zero twice in a row.
// - In ESF the alarm sets after 16 consecutive 00FF patterns on the data link.
// - In ESF the alarm clears when 14 or fewer of 16 pattern slots hold 00FF.
// - Carrier loss sets after 192 consecutive zero bits.
// - Carrier loss clears when 14 of 112 bits, counted from the first one, are ones.
// - The all-ones detector tolerates bit errors and ignores framed all ones.
// - Four alarm flags are exposed: all ones, carrier loss, sync loss, remote.
`timescale 1ns/1ps
`include "t1ra_defs.vh"
module t1ra_alarm_top #(
  parameter AIS_WIN_CYC = `T1RA_AIS_WIN_CYC
) (
  input  wire       i_sys_clk,             // System clock, 10 MHz.
  input  wire       i_sys_rst,             // Synchronous reset, active high.
  input  wire       i_rx_line_clk,         // Recovered receive clock pin.
  input  wire       i_rx_positive_line_in, // Positive rail of received data.
  input  wire       i_rx_negative_line_in, // Negative rail of received data.
  input  wire       i_rx_frame_mark,       // High during each framing bit.
  input  wire       i_rx_mframe_mark,      // High during framing bit of frame 1.
  input  wire       i_rx_sync_loss,        // Loss of frame sync from the framer.
  input  wire [7:0] i_addr,                // Register index.
  input  wire [7:0] i_wr_data,             // Write data.
  input  wire       i_wr_stb,              // Write strobe.
  input  wire       i_rd_stb,              // Read strobe.
  output reg  [7:0] o_rd_data,             // Read data, one cycle after strobe.
  output reg        o_irq,                 // Interrupt, active high level.
  output reg        o_all_ones_alarm_flag, // Unframed all ones received.
  output reg        o_remote_alarm_flag,   // Remote alarm received.
  output reg        o_carrier_loss_flag,   // Carrier loss.
  output reg        o_sync_loss_flag       // Loss of frame sync.
);

  // Next position of a wrapping counter that starts at zero or one.
  function [7:0] wrap_next;
    input [7:0] val;
    input [7:0] last;
    input [7:0] first;
    begin
      if (val == last) begin
        wrap_next = first;
      end else begin
        wrap_next = val + 8'h01;
      end
    end
  endfunction

  // Every line, marker and sync-loss pin passes two flops before any logic reads it.
  reg  [5:0] meta_q;
  reg  [5:0] sync_q;
  reg        line_clk_prev_q;
  wire [5:0] pins;
  wire       bit_stb;
  wire       rx_one;
  wire       frame_mark;
  wire       mframe_mark;

  assign pins = {i_rx_sync_loss, i_rx_mframe_mark, i_rx_frame_mark,
                 i_rx_negative_line_in, i_rx_positive_line_in, i_rx_line_clk};

  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      meta_q          <= 6'h00;
      sync_q          <= 6'h00;
      line_clk_prev_q <= 1'b0;
    end else begin
      meta_q          <= pins;
      sync_q          <= meta_q;
      line_clk_prev_q <= sync_q[0];
    end
  end

  // Data are taken on the rising edge of the line clock; since the pins
  // share the same two-flop path, they stay aligned to that edge.
  assign bit_stb     = sync_q[0] & ~line_clk_prev_q;
  assign rx_one      = sync_q[1] | sync_q[2];
  assign frame_mark  = sync_q[3];
  assign mframe_mark = sync_q[4];

  // Control and mask registers.
  reg  [1:0] ctrl_q;
  reg  [3:0] mask_q;
  wire       mode_sel;
  wire       esf_sel;

  assign mode_sel = ctrl_q[`T1RA_CTRL_MODE_BIT];
  assign esf_sel  = ctrl_q[`T1RA_CTRL_ESF_BIT];

  // Bit and frame position tracking from the framer markers.
  reg  [7:0] bit_pos_q;
  reg  [4:0] frame_q;
  wire [7:0] cur_pos;
  wire [7:0] frame_next;
  wire [4:0] cur_frame;
  wire       is_fbit;
  wire       is_bit2;

  assign cur_pos    = frame_mark ? 8'h00 :
                      wrap_next(bit_pos_q, `T1RA_LAST_BIT_POS, 8'h00);
  assign is_fbit    = (cur_pos == 8'h00);
  assign is_bit2    = ~is_fbit & (cur_pos[2:0] == 3'h2);
  assign frame_next = wrap_next({3'h0, frame_q}, {3'h0, `T1RA_LAST_FRAME}, 8'h01);
  assign cur_frame  = mframe_mark ? 5'h01 : frame_next[4:0];

  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      bit_pos_q <= 8'h00;
      frame_q   <= 5'h01;
    end else if (bit_stb) begin
      bit_pos_q <= cur_pos;
      if (is_fbit) begin
        frame_q <= cur_frame;
      end
    end
  end

  // All-ones alarm: zeros counted over a timed window. A framed all-ones
  // signal still carries framing zeros, so it never falls below the limit.
  wire        ais_done;
  wire [14:0] ais_total;
  reg         ais_q;

  t1ra_window #(.LEN(AIS_WIN_CYC), .W(15)) u_ais_win (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_restart (1'b0),
    .i_step    (1'b1),
    .i_hit     (bit_stb & ~rx_one),
    .o_done    (ais_done),
    .o_total   (ais_total)
  );

  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      ais_q <= 1'b0;
    end else if (ais_done) begin
      ais_q <= (ais_total <= `T1RA_AIS_MAX_ZEROS);
    end
  end

  // Carrier loss: run of zeros sets, ones in a window from the first one clear.
  reg  [7:0] zrun_q;
  reg        los_q;
  reg        los_win_act_q;
  wire       los_step;
  wire       los_done;
  wire [6:0] los_total;

  assign los_step = los_q & bit_stb & (los_win_act_q | rx_one);

  t1ra_window #(.LEN(`T1RA_LOS_WIN_BITS), .W(7)) u_los_win (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_restart (~los_q),
    .i_step    (los_step),
    .i_hit     (rx_one),
    .o_done    (los_done),
    .o_total   (los_total)
  );

  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      zrun_q        <= 8'h00;
      los_q         <= 1'b0;
      los_win_act_q <= 1'b0;
    end else begin
      if (bit_stb) begin
        if (rx_one) begin
          zrun_q <= 8'h00;
        end else if (zrun_q != `T1RA_LOS_ZERO_RUN) begin
          zrun_q <= zrun_q + 8'h01;
        end
      end
      if (zrun_q == `T1RA_LOS_ZERO_RUN) begin
        los_q <= 1'b1;
      end else if (los_done && los_total >= `T1RA_LOS_MIN_ONES) begin
        los_q <= 1'b0;
      end
      // A failed window waits for the next one before starting again.
      if (!los_q || los_done) begin
        los_win_act_q <= 1'b0;
      end else if (los_step) begin
        los_win_act_q <= 1'b1;
      end
    end
  end

  // D4 bit-2 remote alarm over blocks of 256 channel timeslots.
  wire       b2_done;
  wire [8:0] b2_total;
  reg        ras_b2_q;

  t1ra_window #(.LEN(`T1RA_B2_WIN_SLOTS), .W(9)) u_b2_win (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_restart (1'b0),
    .i_step    (bit_stb & is_bit2),
    .i_hit     (~rx_one),
    .o_done    (b2_done),
    .o_total   (b2_total)
  );

  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      ras_b2_q <= 1'b0;
    end else if (b2_done) begin
      ras_b2_q <= (b2_total >= `T1RA_B2_MIN_ZEROS);
    end
  end

  // D4 twelfth framing-bit remote alarm.
  reg        f12_prev_q;
  reg        ras_f12_q;
  wire       f12_stb;

  assign f12_stb = bit_stb & is_fbit & (cur_frame == `T1RA_F12_FRAME);

  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      f12_prev_q <= 1'b0;
      ras_f12_q  <= 1'b0;
    end else if (f12_stb) begin
      f12_prev_q <= rx_one;
      if (rx_one && f12_prev_q) begin
        ras_f12_q <= 1'b1;
      end else if (!rx_one && !f12_prev_q) begin
        ras_f12_q <= 1'b0;
      end
    end
  end

  // ESF data link: the framing bit of every odd frame. Slots are 16 link
  // bits; alignment follows the first pattern seen when no run is open.
  reg  [15:0] fdl_sh_q;
  reg  [3:0]  fdl_cnt_q;
  reg  [4:0]  esf_run_q;
  reg         ras_esf_q;
  wire        fdl_stb;
  wire [15:0] fdl_sh_d;
  wire        fdl_match;
  wire        fdl_slot;
  wire        esf_done;
  wire [4:0]  esf_total;

  assign fdl_stb   = bit_stb & is_fbit & cur_frame[0];
  assign fdl_sh_d  = {fdl_sh_q[14:0], rx_one};
  assign fdl_match = (fdl_sh_d == `T1RA_ESF_PATTERN);
  assign fdl_slot  = fdl_stb & ((fdl_cnt_q == 4'hF) |
                                (fdl_match & (esf_run_q == 5'h00)));

  t1ra_window #(.LEN(`T1RA_ESF_WIN_SLOTS), .W(5)) u_esf_win (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_restart (~ras_esf_q),
    .i_step    (fdl_slot),
    .i_hit     (fdl_match),
    .o_done    (esf_done),
    .o_total   (esf_total)
  );

  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      fdl_sh_q  <= 16'h0000;
      fdl_cnt_q <= 4'h0;
      esf_run_q <= 5'h00;
      ras_esf_q <= 1'b0;
    end else begin
      if (fdl_stb) begin
        fdl_sh_q  <= fdl_sh_d;
        fdl_cnt_q <= fdl_slot ? 4'h0 : fdl_cnt_q + 4'h1;
      end
      if (fdl_slot) begin
        if (!fdl_match) begin
          esf_run_q <= 5'h00;
        end else if (esf_run_q != `T1RA_ESF_RUN) begin
          esf_run_q <= esf_run_q + 5'h01;
        end
      end
      if (esf_run_q == `T1RA_ESF_RUN && !ras_esf_q) begin
        ras_esf_q <= 1'b1;
      end else if (esf_done && esf_total <= `T1RA_ESF_MAX_HITS) begin
        ras_esf_q <= 1'b0;
      end
    end
  end

  // Flag selection and registered outputs.
  reg  [3:0] flags_prev_q;
  reg  [3:0] latch_q;
  reg  [3:0] latch_d;
  wire [3:0] flags;
  wire       ras_sel;
  wire       latch_rd;

  assign ras_sel = esf_sel ? ras_esf_q :
                   (mode_sel ? ras_f12_q : ras_b2_q);

  assign flags[`T1RA_FLG_SYNC]     = sync_q[5];
  assign flags[`T1RA_FLG_CARRIER]  = los_q;
  assign flags[`T1RA_FLG_REMOTE]   = ras_sel;
  assign flags[`T1RA_FLG_ALL_ONES] = ais_q;

  assign latch_rd = i_rd_stb & (i_addr == `T1RA_REG_LATCH);

  // A flag that rises in the cycle of a clearing read stays latched.
  always @* begin
    latch_d = latch_q;
    if (latch_rd) begin
      latch_d = 4'h0;
    end
    latch_d = latch_d | (flags & ~flags_prev_q);
  end

  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      flags_prev_q          <= `T1RA_FLG_RST;
      latch_q               <= `T1RA_FLG_RST;
      o_irq                 <= 1'b0;
      o_all_ones_alarm_flag <= 1'b0;
      o_remote_alarm_flag   <= 1'b0;
      o_carrier_loss_flag   <= 1'b0;
      o_sync_loss_flag      <= 1'b0;
    end else begin
      flags_prev_q          <= flags;
      latch_q               <= latch_d;
      o_irq                 <= |(latch_d & mask_q);
      o_all_ones_alarm_flag <= flags[`T1RA_FLG_ALL_ONES];
      o_remote_alarm_flag   <= flags[`T1RA_FLG_REMOTE];
      o_carrier_loss_flag   <= flags[`T1RA_FLG_CARRIER];
      o_sync_loss_flag      <= flags[`T1RA_FLG_SYNC];
    end
  end

  // Register port: writes take effect at once, reads answer next cycle.
  // Unmapped indices read as zero and ignore writes.
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      ctrl_q    <= `T1RA_CTRL_RST;
      mask_q    <= `T1RA_MASK_RST;
      o_rd_data <= 8'h00;
    end else begin
      if (i_wr_stb) begin
        case (i_addr)
          `T1RA_REG_CTRL: begin
            ctrl_q <= i_wr_data[1:0];
          end
          `T1RA_REG_MASK: begin
            mask_q <= i_wr_data[3:0];
          end
          default: begin
          end
        endcase
      end
      o_rd_data <= 8'h00;
      if (i_rd_stb) begin
        case (i_addr)
          `T1RA_REG_CTRL: begin
            o_rd_data <= {6'h00, ctrl_q};
          end
          `T1RA_REG_STATUS: begin
            o_rd_data <= {4'h0, flags};
          end
          `T1RA_REG_LATCH: begin
            o_rd_data <= {4'h0, latch_q | (flags & ~flags_prev_q)};
          end
          `T1RA_REG_MASK: begin
            o_rd_data <= {4'h0, mask_q};
          end
          default: begin
            o_rd_data <= 8'h00;
          end
        endcase
      end
    end
  end

endmodule // t1ra_alarm_top

/* hdl/t1ra_defs.vh */
// Constants for the T1 receive alarm detector: register map, field
// positions, reset values and timing counts.
// Assumes a 10 MHz system clock and a T1 stream of 193-bit frames.
`ifndef T1RA_DEFS_VH
`define T1RA_DEFS_VH

// Register indices on the plain register port.
`define T1RA_REG_CTRL       8'h00
`define T1RA_REG_STATUS     8'h01
`define T1RA_REG_LATCH      8'h02
`define T1RA_REG_MASK       8'h03

// Control register fields.
`define T1RA_CTRL_MODE_BIT  0
`define T1RA_CTRL_ESF_BIT   1
`define T1RA_CTRL_RST       2'h0

// Flag positions, shared by status, latch and mask registers.
`define T1RA_FLG_SYNC       0
`define T1RA_FLG_CARRIER    1
`define T1RA_FLG_REMOTE     2
`define T1RA_FLG_ALL_ONES   3
`define T1RA_FLG_RST        4'h0
`define T1RA_MASK_RST       4'h0

// Line format.
`define T1RA_LAST_BIT_POS   8'hC0
`define T1RA_LAST_FRAME     5'h18
`define T1RA_F12_FRAME      5'h0C

// Alarm thresholds.
`define T1RA_AIS_MAX_ZEROS  15'h0005
`define T1RA_LOS_ZERO_RUN   8'hC0
`define T1RA_LOS_WIN_BITS   112
`define T1RA_LOS_MIN_ONES   7'h0E
`define T1RA_B2_WIN_SLOTS   256
`define T1RA_B2_MIN_ZEROS   9'h0FE
`define T1RA_ESF_PATTERN    16'h00FF
`define T1RA_ESF_RUN        5'h10
`define T1RA_ESF_WIN_SLOTS  16
`define T1RA_ESF_MAX_HITS   5'h0E

// Timing.
`define T1RA_SYS_CLK_HZ     10000000
`define T1RA_AIS_WIN_MS     3
`define T1RA_AIS_WIN_CYC    (`T1RA_AIS_WIN_MS * (`T1RA_SYS_CLK_HZ / 1000))

`endif

/* hdl/t1ra_window.v */
// Counts hits over a fixed number of steps and reports the total at the
// end of every window.
// Assumes i_step and i_hit come from logic on the same clock.
`timescale 1ns/1ps
module t1ra_window #(
  parameter LEN = 256,
  parameter W   = 9
) (
  input  wire         i_sys_clk, // System clock.
  input  wire         i_sys_rst, // Synchronous reset, active high.
  input  wire         i_restart, // Holds the window at its start.
  input  wire         i_step,    // Advances the window by one position.
  input  wire         i_hit,     // Counts this position as a hit.
  output reg          o_done,    // One-cycle pulse at window end.
  output reg  [W-1:0] o_total    // Hits in the window just ended.
);
  localparam [W-1:0] LAST = LEN[W-1:0] - {{(W-1){1'b0}}, 1'b1};

  reg  [W-1:0] pos_q;
  reg  [W-1:0] cnt_q;
  wire [W-1:0] cnt_inc;

  assign cnt_inc = cnt_q + {{(W-1){1'b0}}, i_hit};

  always @(posedge i_sys_clk) begin
    if (i_sys_rst || i_restart) begin
      pos_q   <= {W{1'b0}};
      cnt_q   <= {W{1'b0}};
      o_done  <= 1'b0;
      o_total <= {W{1'b0}};
    end else begin
      o_done <= 1'b0;
      if (i_step) begin
        if (pos_q == LAST) begin
          o_done  <= 1'b1;
          o_total <= cnt_inc;
          pos_q   <= {W{1'b0}};
          cnt_q   <= {W{1'b0}};
        end else begin
          pos_q <= pos_q + {{(W-1){1'b0}}, 1'b1};
          cnt_q <= cnt_inc;
        end
      end
    end
  end
endmodule // t1ra_window
